/* src/mcx_ctrl.sv */
// memory controller: cpu local port, wishbone registers, dram/sram pins
// assumes cpu request held until ack; data bus driven only while busy, address and strobe pins always driven
`timescale 1ns/100ps
`include "mcx_defs.svh"

module mcx_ctrl
   import mcx_pkg::*;
#(
   parameter logic [3:0] CAS_CYC = `MCX_CAS_CYC
)(
   input  wire logic        clk_i,
   input  wire logic        rst_i,
   input  wire logic        wb_cyc_i,
   input  wire logic        wb_stb_i,
   input  wire logic        wb_we_i,
   input  wire logic [31:0] wb_adr_i,
   input  wire logic [3:0]  wb_sel_i,
   input  wire logic [31:0] wb_dat_i,
   output logic      [31:0] wb_dat_o,
   output logic             wb_ack_o,
   input  wire logic        cpu_req_i,
   input  wire logic        cpu_we_i,
   input  wire logic [23:1] cpu_addr_i,
   input  wire logic [1:0]  cpu_be_i,
   input  wire logic [15:0] cpu_wdata_i,
   output logic      [15:0] cpu_rdata_o,
   output logic             cpu_ack_o,
   output logic             cpu_err_o,
   output logic             mem_busy_o,
   output logic      [23:12] upper_system_address_o,
   output logic      [11:1] sa_lo_o,
   output logic      [1:0]  ras_n_o,
   output logic      [3:0]  cas_n_o,
   output logic             mwe_n_o,
   input  wire logic [15:0] shared_data_bus_i,
   output logic      [15:0] shared_data_bus_o,
   output logic             shared_data_bus_oe_n_o
);
   // register file
   logic [7:0]  memcfg_r, memcfg_nxt;
   logic [7:0]  misc_r, misc_nxt;
   logic [7:0]  banksel_r, banksel_nxt;
   logic [7:0]  card_r, card_nxt;
   logic [10:0] pmap_r [`MCX_PMAP_COUNT];
   logic        ack_r, ack_nxt;
   logic [31:0] dat_r, dat_nxt;
   logic        wr_en;
   logic [7:0]  idx;
   mcx_mode_t   mode;
   logic        cfg_bad;

   assign idx   = wb_adr_i[9:2];
   assign wr_en = wb_cyc_i && wb_stb_i && wb_we_i && !ack_r && wb_sel_i[0];
   assign wb_ack_o = ack_r;
   assign wb_dat_o = dat_r;

   always_comb
   begin
      memcfg_nxt  = memcfg_r;
      misc_nxt    = misc_r;
      banksel_nxt = banksel_r;
      card_nxt    = card_r;
      ack_nxt     = wb_cyc_i && wb_stb_i && !ack_r;
      dat_nxt     = dat_r;
      if (wr_en && idx == `MCX_IDX_MEMCFG)
         memcfg_nxt = wb_dat_i[7:0];
      else if (wr_en && idx == `MCX_IDX_MISC)
         misc_nxt = wb_dat_i[7:0];
      else if (wr_en && idx == `MCX_IDX_BANKSEL)
         banksel_nxt = wb_dat_i[7:0];
      else if (wr_en && idx == `MCX_IDX_CARD)
         card_nxt = wb_dat_i[7:0];
      if (ack_nxt && !wb_we_i)
      begin
         if (idx == `MCX_IDX_MEMCFG)
            dat_nxt = {24'h000000, memcfg_r};
         else if (idx == `MCX_IDX_MISC)
            dat_nxt = {24'h000000, misc_r};
         else if (idx == `MCX_IDX_BANKSEL)
            dat_nxt = {24'h000000, banksel_r};
         else if (idx == `MCX_IDX_CARD)
            dat_nxt = {24'h000000, card_r};
         else if (idx >= `MCX_IDX_PMAP0 && idx < `MCX_IDX_PMAP0 + 8'(`MCX_PMAP_COUNT))
            dat_nxt = {21'h000000, pmap_r[4'(idx - `MCX_IDX_PMAP0)]};
         else if (idx == `MCX_IDX_STATUS)
            dat_nxt = {27'h0000000, cfg_bad, mode, mem_busy_o};
         else
            dat_nxt = 32'h00000000;
      end
   end

   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         memcfg_r  <= `MCX_RST_MEMCFG;
         misc_r    <= `MCX_RST_MISC;   // dram interface after reset
         banksel_r <= `MCX_RST_BANKSEL;
         card_r    <= `MCX_RST_CARD;
         ack_r     <= 1'b0;
         dat_r     <= 32'h00000000;
      end
      else
      begin
         memcfg_r  <= memcfg_nxt;
         misc_r    <= misc_nxt;
         banksel_r <= banksel_nxt;
         card_r    <= card_nxt;
         ack_r     <= ack_nxt;
         dat_r     <= dat_nxt;
      end
   end

   // page registers: enable in bit 10, target 16k page in bits 9:0
   genvar g;
   generate
      for (g = 0; g < `MCX_PMAP_COUNT; g++)
      begin : g_pmap
         logic [10:0] pm_nxt;
         always_comb
         begin
            pm_nxt = pmap_r[g];
            if (wr_en && idx == `MCX_IDX_PMAP0 + 8'(g))
               pm_nxt = wb_dat_i[10:0];
         end
         always_ff @(posedge clk_i)
         begin
            if (rst_i)
               pmap_r[g] <= `MCX_RST_PMAP;
            else
               pmap_r[g] <= pm_nxt;
         end
      end
   endgenerate

   // mode and configuration legality
   always_comb
   begin
      if (misc_r[`MCX_BIT_SRAM])
         mode = MODE_SRAM;
      else if (memcfg_r[`MCX_BIT_MODE])
         mode = MODE_EPM;
      else
         mode = MODE_PAGE;
   end

   // row/column multiplexing per bank configuration
   function automatic mcx_map_t addr_map(input logic [23:1] a, input logic [2:0] ms,
                                         input logic asym, input logic [1:0] bs,
                                         input logic enh);
      mcx_map_t m;
      m.row      = 12'h000;
      m.col      = {3'h0, a[9:1]};
      m.bank     = 1'b0;
      m.two_bank = 1'b0;
      m.ok       = 1'b1;
      if (asym)
      begin
         case (bs)
            2'b00: m.row = {3'h0, a[18:10]};
            2'b01:
            begin
               m.row      = {3'h0, a[18:10]};
               m.bank     = a[19];
               m.two_bank = 1'b1;
            end
            2'b10:
            begin
               m.row = {a[20], a[9], a[19:10]};
               m.col = {4'h0, a[8:1]};
            end
            default:
            begin
               m.row = {a[20], a[21], a[19:10]};
               m.col = {4'h0, a[8:1]};
               m.bank = a[9];
               m.ok   = enh;                        // page mode cannot do this
            end
         endcase
      end
      else
      begin
         case (ms)
            3'b001: m.row = {2'h0, a[19:10]};
            3'b010:
            begin
               m.row = {2'h0, a[19:10]};
               m.bank = a[20];
               m.two_bank = 1'b1;
            end
            3'b011:
            begin
               m.row = {2'h0, a[19:11], a[20]};
               m.col = {2'h0, a[10:1]};
            end
            3'b100:
            begin
               m.row = {2'h0, a[19:11], a[20]};
               m.col = {2'h0, a[10:1]};
               m.bank = a[21];
               m.two_bank = 1'b1;
            end
            3'b101:
            begin
               m.row = {1'b0, a[22], a[19:12], a[21], a[20]};
               m.col = {1'b0, a[11:1]};
            end
            3'b110:
            begin
               m.row = {1'b0, a[22], a[19:12], a[21], a[20]};
               m.col = {1'b0, a[11:1]};
               m.bank = a[23];
               m.two_bank = 1'b1;
            end
            default: m.ok = 1'b0;                   // no memory configured
         endcase
      end
      // bank from lowest row bit, row bit 0 from a[19]^a[20]^a[21]^a[23]: adjacent pages alternate banks where row bit 0 is a[10]
      if (enh && m.two_bank && !(asym && bs == 2'b11))
      begin
         m.bank   = m.row[0];
         m.row[0] = a[20] ^ a[21] ^ a[23] ^ a[19];
      end
      return m;
   endfunction : addr_map

   // cpu window remap through the page registers
   logic [23:1] phys_a;
   logic [9:0]  win;
   always_comb
   begin
      phys_a = cpu_addr_i;
      win    = cpu_addr_i[23:14] - `MCX_MAP_BASE;
      if (win < 10'(`MCX_PMAP_COUNT) && pmap_r[4'(win)][`MCX_PMAP_EN])
         phys_a[23:14] = pmap_r[4'(win)][9:0];
   end

   mcx_map_t amap;
   assign amap = addr_map(phys_a, memcfg_r[`MCX_MS_HI:`MCX_MS_LO], card_r[`MCX_BIT_ASYM],
                          banksel_r[`MCX_BS_HI:`MCX_BS_LO], mode == MODE_EPM);
   assign cfg_bad = !amap.ok
                  || (mode == MODE_SRAM && card_r[`MCX_BIT_ASYM])
                  || (mode != MODE_SRAM && !memcfg_r[`MCX_BIT_DRAM]);

   // data input synchroniser: three flops, accept when last two agree
   logic [15:0] din1_r, din2_r, din3_r, din_r, din_nxt;
   always_comb
   begin
      din_nxt = din_r;
      if (din2_r == din3_r)
         din_nxt = din3_r;
   end
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         din1_r <= 16'h0000;
         din2_r <= 16'h0000;
         din3_r <= 16'h0000;
         din_r  <= 16'h0000;
      end
      else
      begin
         din1_r <= shared_data_bus_i;
         din2_r <= din1_r;
         din3_r <= din2_r;
         din_r  <= din_nxt;
      end
   end

   // access sequencer, clocked only by the cpu clock
   mcx_state_t  st_r, st_nxt;
   logic [3:0]  cnt_r, cnt_nxt;
   mcx_map_t    map_r, map_nxt;
   logic [23:1] pa_r, pa_nxt;
   logic        we_r, we_nxt, err_r, err_nxt, sram_r, sram_nxt;
   logic [1:0]  be_r, be_nxt;
   logic [15:0] wdat_r, wdat_nxt, rdat_r, rdat_nxt;
   logic [11:0] ma_r, ma_nxt;
   logic [1:0]  ras_r, ras_nxt;
   logic [3:0]  cas_r, cas_nxt;
   logic        mwe_r, mwe_nxt, oe_r, oe_nxt;
   logic [3:0]  lanes;

   assign lanes = map_r.bank ? {~be_r, 2'b11} : {2'b11, ~be_r};

   always_comb
   begin
      st_nxt   = st_r;
      cnt_nxt  = cnt_r;
      map_nxt  = map_r;
      pa_nxt   = pa_r;
      we_nxt   = we_r;
      be_nxt   = be_r;
      wdat_nxt = wdat_r;
      rdat_nxt = rdat_r;
      err_nxt  = err_r;
      sram_nxt = sram_r;
      ma_nxt   = ma_r;
      ras_nxt  = ras_r;
      cas_nxt  = cas_r;
      mwe_nxt  = mwe_r;
      oe_nxt   = oe_r;
      case (st_r)
         ST_IDLE:
         begin
            if (cpu_req_i && !cpu_ack_o)
            begin
               map_nxt  = amap;
               pa_nxt   = phys_a;
               we_nxt   = cpu_we_i;
               be_nxt   = cpu_be_i;
               wdat_nxt = cpu_wdata_i;
               err_nxt  = cfg_bad;
               sram_nxt = mode == MODE_SRAM;
               if (cfg_bad)
                  st_nxt = ST_DONE;
               else if (mode == MODE_SRAM)
               begin
                  // wait states from config bits 1:0; reads also wait out the pin sync
                  cnt_nxt = (memcfg_r[1:0] == 2'b00 ? {3'h0, cpu_we_i}
                          : (memcfg_r[1] ? 4'h2 : 4'h1))
                          + (cpu_we_i ? 4'h0 : CAS_CYC - 4'h1);
                  st_nxt  = ST_SRAM;
                  mwe_nxt = !cpu_we_i;
                  oe_nxt  = !cpu_we_i;
                  cas_nxt = amap.bank ? {~cpu_be_i, 2'b11} : {2'b11, ~cpu_be_i};
               end
               else
               begin
                  ma_nxt = amap.row;
                  st_nxt = ST_ROW;
               end
            end
         end
         ST_ROW:
         begin
            ras_nxt = map_r.bank ? 2'b01 : 2'b10;
            st_nxt  = ST_RAS;
         end
         ST_RAS:
         begin
            ma_nxt  = map_r.col;
            mwe_nxt = !we_r;
            oe_nxt  = !we_r;
            st_nxt  = ST_COL;
         end
         ST_COL:
         begin
            cas_nxt = lanes;
            cnt_nxt = CAS_CYC - 4'h1;
            st_nxt  = ST_CAS;
         end
         ST_CAS, ST_SRAM:
         begin
            if (cnt_r == 4'h0)
            begin
               // sync delay: capture only after data has crossed three flops
               if (!we_r)
                  rdat_nxt = din_r;
               ras_nxt = 2'b11;
               cas_nxt = 4'hf;
               mwe_nxt = 1'b1;
               oe_nxt  = 1'b1;
               st_nxt  = ST_DONE;
            end
            else
               cnt_nxt = cnt_r - 4'h1;
         end
         ST_DONE: st_nxt = ST_IDLE;
         default: st_nxt = ST_IDLE;
      endcase
   end

   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         st_r   <= ST_IDLE;
         cnt_r  <= 4'h0;
         map_r  <= '0;
         pa_r   <= '0;
         we_r   <= 1'b0;
         be_r   <= 2'b00;
         wdat_r <= 16'h0000;
         rdat_r <= 16'h0000;
         err_r  <= 1'b0;
         sram_r <= 1'b0;
         ma_r   <= 12'h000;
         ras_r  <= 2'b11;
         cas_r  <= 4'hf;
         mwe_r  <= 1'b1;
         oe_r   <= 1'b1;
      end
      else
      begin
         st_r   <= st_nxt;
         cnt_r  <= cnt_nxt;
         map_r  <= map_nxt;
         pa_r   <= pa_nxt;
         we_r   <= we_nxt;
         be_r   <= be_nxt;
         wdat_r <= wdat_nxt;
         rdat_r <= rdat_nxt;
         err_r  <= err_nxt;
         sram_r <= sram_nxt;
         ma_r   <= ma_nxt;
         ras_r  <= ras_nxt;
         cas_r  <= cas_nxt;
         mwe_r  <= mwe_nxt;
         oe_r   <= oe_nxt;
      end
   end

   // pins drive memory directly; no buffer direction logic
   assign mem_busy_o  = st_r != ST_IDLE;
   assign cpu_ack_o   = st_r == ST_DONE;
   assign cpu_err_o   = err_r;
   assign cpu_rdata_o = rdat_r;
   assign ras_n_o     = ras_r;
   assign cas_n_o     = cas_r;
   assign mwe_n_o     = mwe_r;
   assign shared_data_bus_o      = wdat_r;
   assign shared_data_bus_oe_n_o = oe_r;
   assign sa_lo_o = sram_r ? pa_r[11:1] : 11'h000;
   assign upper_system_address_o = sram_r ? pa_r[23:12]
                                 : {ma_r[9:0], ma_r[10], ma_r[11]};

   default clocking cb @(posedge clk_i); endclocking
   default disable iff (rst_i);

   a_mode_onehot: assert property ($onehot(mode)) else $error("mode not one-hot");
   a_sram_select: assert property (misc_r[0] |-> mode == MODE_SRAM)
      else $error("sram bit ignored");
   a_dram_mode: assert property (!misc_r[0] |-> mode == (memcfg_r[0] ? MODE_EPM : MODE_PAGE))
      else $error("dram mode bit ignored");
   a_pin_share: assert property (!sram_r |-> upper_system_address_o[23:14] == ma_r[9:0]
      && upper_system_address_o[12] == ma_r[11]) else $error("address sharing wrong");
   a_row_col_seq: assert property (st_r == ST_ROW |-> ma_r == map_r.row ##1 ras_n_o != 2'b11
      ##1 cas_n_o == 4'hf ##1 ma_r == map_r.col && cas_n_o != 4'hf)
      else $error("row/column order broken");
   a_bus_write: assert property (!shared_data_bus_oe_n_o |-> we_r && mem_busy_o)
      else $error("data bus driven outside write");
   a_sram_block: assert property (st_r == ST_IDLE && cpu_req_i && !cpu_ack_o && misc_r[0]
      && card_r[7] |=> st_r == ST_DONE && err_r) else $error("sram allowed with card bit");
   a_no_pm_2x1m: assert property (st_r == ST_IDLE && cpu_req_i && !cpu_ack_o && !misc_r[0]
      && card_r[7] && banksel_r[7:6] == 2'b11 && !memcfg_r[0] |=> st_r == ST_DONE)
      else $error("page mode two 1m banks accepted");
   a_req_served: assert property (st_r == ST_IDLE && cpu_req_i && !cpu_ack_o
      |-> ##[1:24] cpu_ack_o) else $error("cpu request not answered");
   a_ack_pulse: assert property (cpu_ack_o |=> !cpu_ack_o) else $error("ack longer than 1");
endmodule : mcx_ctrl

/* src/mcx_defs.svh */
// register offsets, field positions, reset values and timing counts
// assumes an 8-bit register index carried on wb_adr_i[9:2]
`ifndef MCX_DEFS_SVH
`define MCX_DEFS_SVH
`define MCX_IDX_MEMCFG   8'h66
`define MCX_IDX_MISC     8'h70
`define MCX_IDX_BANKSEL  8'hb1
`define MCX_IDX_CARD     8'hb4
`define MCX_IDX_PMAP0    8'hc0
`define MCX_IDX_STATUS   8'hd0
`define MCX_PMAP_COUNT   12
`define MCX_BIT_MODE     0
`define MCX_BIT_DRAM     1
`define MCX_MS_HI        4
`define MCX_MS_LO        2
`define MCX_BIT_SRAM     0
`define MCX_BIT_ASYM     7
`define MCX_BS_HI        7
`define MCX_BS_LO        6
`define MCX_PMAP_EN      10
`define MCX_RST_MEMCFG   8'h06
`define MCX_RST_MISC     8'h00
`define MCX_RST_BANKSEL  8'h00
`define MCX_RST_CARD     8'h00
`define MCX_RST_PMAP     11'h000
`define MCX_CAS_CYC      4'h5
`define MCX_MAP_BASE     10'h030
`endif

/* src/mcx_pkg.sv */
// types shared by the memory controller
// assumes mcx_defs.svh holds the numeric constants
package mcx_pkg;
   typedef enum logic [2:0] {
      MODE_SRAM = 3'b001,
      MODE_PAGE = 3'b010,
      MODE_EPM  = 3'b100
   } mcx_mode_t;
   typedef enum logic [6:0] {
      ST_IDLE = 7'b0000001,
      ST_ROW  = 7'b0000010,
      ST_RAS  = 7'b0000100,
      ST_COL  = 7'b0001000,
      ST_CAS  = 7'b0010000,
      ST_SRAM = 7'b0100000,
      ST_DONE = 7'b1000000
   } mcx_state_t;
   typedef struct packed {
      logic [11:0] row;
      logic [11:0] col;
      logic        bank;
      logic        two_bank;
      logic        ok;
   } mcx_map_t;
endpackage : mcx_pkg

/* test/mcx_mem_model.sv */
// far-side model: one or two 16-bit banks of page dram, or sram
// assumes strobes and multiplexed address come straight from the controller
`timescale 1ns/100ps
module mcx_mem_model
(
   input  wire logic         clk_i,
   input  wire logic [1:0]   ras_n_i,
   input  wire logic [3:0]   cas_n_i,
   input  wire logic         we_n_i,
   input  wire logic [23:12] usa_i,
   input  wire logic [11:1]  sa_lo_i,
   input  wire logic [15:0]  dq_i,
   output logic      [15:0]  dq_o
);
   logic [15:0] mem [int];
   logic [11:0] ma;
   logic [11:0] row_r;
   logic [15:0] last_r;
   logic [15:0] w;
   int          key;
   assign ma = {usa_i[12], usa_i[13], usa_i[23:14]};
   initial last_r = 16'h0000;
   always @(negedge ras_n_i[0] or negedge ras_n_i[1])
      row_r = ma;
   always @*
   begin
      if (ras_n_i == 2'b11)
         key = int'({8'h01, usa_i, sa_lo_i});
      else
         key = int'({~ras_n_i[1], row_r, ma});
   end
   // lanes as chip selects in sram mode, column strobes in dram mode
   always @(posedge clk_i)
   begin
      if (!we_n_i && cas_n_i != 4'hf)
      begin
         w = mem.exists(key) ? mem[key] : 16'h0000;
         if (!(cas_n_i[0] & cas_n_i[2]))
            w[7:0] = dq_i[7:0];
         if (!(cas_n_i[1] & cas_n_i[3]))
            w[15:8] = dq_i[15:8];
         mem[key] = w;
      end
      last_r <= dq_o;
   end
   // released bus shows a changing pattern, never the old value
   always @*
   begin
      if (we_n_i && cas_n_i != 4'hf && mem.exists(key))
         dq_o = mem[key];
      else
         dq_o = ~last_r;
   end
endmodule : mcx_mem_model

/* test/mcx_ctrl_test.sv */
// self-checking bench: wishbone register tasks and cpu port tasks
// assumes mcx_mem_model on the far side; data bus resolved from oe_n
`timescale 1ns/100ps
module mcx_ctrl_test;
   logic         clk_i, rst_i, cyc, stb, we, ack, req, cwe, cack, cerr, busy, mwe_n, oe_n;
   logic [31:0]  adr, wdat, rdat, r;
   logic [3:0]   sel, cas_n;
   logic [23:1]  caddr, sa_seen;
   logic [1:0]   be, ras_n, bank_n, b0;
   logic [15:0]  cwd, crd, dq_ctl, dq_mem, dq_bus, rd_data;
   logic [23:12] usa;
   logic [11:1]  sa_lo;
   logic [11:0]  ma, row_ma, col_ma;
   logic         got_row, err_seen, busy_seen;
   logic [2:0]   wext;
   logic [15:0]  reg_tab [6] = '{16'h6606, 16'h7000, 16'hb100, 16'hb400, 16'hd004, 16'h1000};
   logic [31:0]  bad_tab [4] = '{32'h02000000, 32'h04000000, 32'h0680c000, 32'h04800001};
   int           failures, compares, cycles;
   assign ma = {usa[12], usa[13], usa[23:14]};
   assign dq_bus = oe_n ? dq_mem : dq_ctl;
   mcx_ctrl #(.CAS_CYC(4'h5)) dut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb),
      .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat),
      .wb_ack_o(ack), .cpu_req_i(req), .cpu_we_i(cwe), .cpu_addr_i(caddr), .cpu_be_i(be),
      .cpu_wdata_i(cwd), .cpu_rdata_o(crd), .cpu_ack_o(cack), .cpu_err_o(cerr),
      .mem_busy_o(busy), .upper_system_address_o(usa), .sa_lo_o(sa_lo), .ras_n_o(ras_n),
      .cas_n_o(cas_n), .mwe_n_o(mwe_n), .shared_data_bus_i(dq_bus),
      .shared_data_bus_o(dq_ctl), .shared_data_bus_oe_n_o(oe_n));
   mcx_mem_model mem (.clk_i(clk_i), .ras_n_i(ras_n), .cas_n_i(cas_n), .we_n_i(mwe_n),
      .usa_i(usa), .sa_lo_i(sa_lo), .dq_i(dq_ctl), .dq_o(dq_mem));
   initial
   begin
      clk_i = 1'b0;
      forever #50 clk_i = ~clk_i;
   end
   task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
      compares++;
      if (got !== exp)
      begin
         failures++;
         $display("[FAIL] %s expected %h seen %h", what, exp, got);
      end
   endtask : check
   task automatic wb(input logic w, input logic [7:0] idx, input logic [7:0] d);
      @(posedge clk_i);
      cyc <= 1'b1;
      stb <= 1'b1;
      we <= w;
      adr <= {22'h0, idx, 2'b00};
      wdat <= {21'h0, wext, d};
      do @(posedge clk_i); while (ack !== 1'b1);
      r = rdat;
      cyc <= 1'b0;
      stb <= 1'b0;
   endtask : wb
   task automatic cpu(input logic w, input logic [23:0] ba, input logic [15:0] d);
      got_row = 1'b0;
      row_ma = 12'h000;
      col_ma = 12'h000;
      @(posedge clk_i);
      req <= 1'b1;
      cwe <= w;
      caddr <= ba[23:1];
      cwd <= d;
      do
      begin
         @(posedge clk_i);
         if (!got_row && ras_n !== 2'b11)
         begin
            got_row = 1'b1;
            row_ma = ma;
            bank_n = ras_n;
         end
         if (cas_n !== 4'hf)
         begin
            col_ma = ma;
            sa_seen = {usa, sa_lo};
         end
      end while (cack !== 1'b1);
      rd_data = crd;
      err_seen = cerr;
      busy_seen = busy;
      req <= 1'b0;
   endtask : cpu
   task automatic dram(input logic [23:0] cfg, input int kind, input logic [23:0] ba);
      logic [15:0] d;
      d = ba[16:1] ^ 16'h5aa5;
      wb(1'b1, 8'h66, cfg[23:16]);
      wb(1'b1, 8'hb4, cfg[15:8]);
      wb(1'b1, 8'hb1, cfg[7:0]);
      cpu(1'b1, ba, d);
      cpu(1'b0, ba, 16'h0000);
      check("dram data", {16'h0, d}, {16'h0, rd_data});
      check("dram error", 32'h0, {31'h0, err_seen});
      check("busy at ack", 32'h1, {31'h0, busy_seen});
      case (kind)
         0: check("row", {22'h0, ba[19:10]}, {22'h0, row_ma[9:0]});
         1: check("row", {21'h0, ba[22], ba[19:12], ba[21:20]}, {21'h0, row_ma[10:0]});
         2: check("row", {21'h0, ba[20:10]}, {21'h0, row_ma[11], row_ma[9:0]});
         default: check("row", {23'h0, ba[18:10]}, {23'h0, row_ma[8:0]});
      endcase
      case (kind)
         1: check("col", {21'h0, ba[11:1]}, {21'h0, col_ma[10:0]});
         2: check("col", {24'h0, ba[8:1]}, {24'h0, col_ma[7:0]});
         default: check("col", {23'h0, ba[9:1]}, {23'h0, col_ma[8:0]});
      endcase
   endtask : dram
   task automatic conclude();
      $display("compares %0d failures %0d", compares, failures);
      if (failures == 0 && compares > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask : conclude
   // hang guard, well above the few hundred cycles the tests take
   always @(posedge clk_i)
   begin
      cycles++;
      if (cycles == 20000)
      begin
         failures++;
         conclude();
      end
   end
   initial
   begin
      {rst_i, cyc, stb, we, req, cwe} = 6'b100000;
      {adr, wdat, caddr, cwd} = '0;
      sel = 4'h1;
      be = 2'b11;
      wext = 3'h0;
      repeat (16) @(posedge clk_i);
      rst_i <= 1'b0;
      wb(1'b1, 8'h10, 8'hff);
      foreach (reg_tab[i])
      begin
         wb(1'b0, reg_tab[i][15:8], 8'h00);
         check("reset value", {24'h0, reg_tab[i][7:0]}, r);
      end
      $display("test registers done");
      for (int m = 0; m < 2; m++)
      begin
         wb(1'b1, 8'h66, m ? 8'h0b : 8'h0a);
         wb(1'b0, 8'hd0, 8'h00);
         check("status mode", m ? 4 : 2, {29'h0, r[3:1]});
         cpu(1'b0, 24'h012000, 16'h0000);
         b0 = bank_n;
         cpu(1'b0, 24'h012400, 16'h0000);
         check("bank split", m, {31'h0, b0 !== bank_n});
      end
      $display("test enhanced done");
      dram(24'h060000, 0, 24'h0b5b3a);
      dram(24'h160000, 1, 24'h6d5b3a);
      dram(24'h068080, 2, 24'h1b5b3a);
      dram(24'h068000, 3, 24'h05b33a);
      $display("test dram mapping done");
      foreach (bad_tab[i])
      begin
         wb(1'b1, 8'h66, bad_tab[i][31:24]);
         wb(1'b1, 8'hb4, bad_tab[i][23:16]);
         wb(1'b1, 8'hb1, bad_tab[i][15:8]);
         wb(1'b1, 8'h70, bad_tab[i][7:0]);
         cpu(1'b1, 24'h001000, 16'h1234);
         check("refused", 32'h1, {31'h0, err_seen & ~got_row});
      end
      $display("test refusals done");
      wb(1'b1, 8'hb4, 8'h00);
      cpu(1'b1, 24'h0f3c6e, 16'hc3e1);
      cpu(1'b0, 24'h0f3c6e, 16'h0000);
      check("sram data", 32'hc3e1, {16'h0, rd_data});
      check("sram address", {8'h0, 24'h0f3c6e >> 1}, {9'h0, sa_seen});
      check("sram no row", 32'h0, {31'h0, got_row});
      wb(1'b0, 8'hd0, 8'h00);
      check("status mode", 32'h1, {29'h0, r[3:1]});
      $display("test sram done");
      // page register 0 enabled: window base page redirected to page 0x012
      wext = 3'h4;
      wb(1'b1, 8'hc0, 8'h12);
      wext = 3'h0;
      wb(1'b0, 8'hc0, 8'h00);
      check("page register", 32'h412, r);
      cpu(1'b1, 24'h0c1234, 16'h6b2d);
      check("remapped address", {8'h0, 24'h049234 >> 1}, {9'h0, sa_seen});
      cpu(1'b0, 24'h049234, 16'h0000);
      check("remapped data", 32'h6b2d, {16'h0, rd_data});
      $display("test page mapping done");
      conclude();
   end
endmodule : mcx_ctrl_test
